/* design/pic_pkg.sv */
// Constants shared by the prioritised interrupt controller.
package pic_pkg;
	localparam int NUM_SRC = 82;
	localparam int NUM_W = 7;
	localparam int BASE_W = 14;
	localparam int ADDR_W = BASE_W + NUM_W;
	localparam int FAST_LO_W = 16;
	localparam int FAST_HI_W = ADDR_W - FAST_LO_W;
	// Sources below this index are fixed at the top level and ignore their level field.
	localparam int FIXED_SRC_CNT = 2;
	localparam logic [1:0] FIXED_LEVEL = 2'h3;
	// Level that marks a request as a fast-interrupt candidate.
	localparam logic [1:0] FAST_LEVEL = 2'h2;
	// Source numbers of the two external request pins and the CAN wake-up source.
	localparam logic [NUM_W-1:0] EXT_A_SRC = 7'h09;
	localparam logic [NUM_W-1:0] EXT_B_SRC = 7'h0A;
	localparam logic [NUM_W-1:0] CAN_WAKE_SRC = 7'h1C;
	// Current-level codes reported to the core.
	localparam logic [1:0] CODE_NONE = 2'h0;
	localparam logic [1:0] CODE_LVL0 = 2'h1;
	localparam logic [1:0] CODE_LVL1 = 2'h2;
	localparam logic [1:0] CODE_LVL23 = 2'h3;
	// Nesting depth: one entry per level is always enough for strict preemption.
	localparam int STACK_DEPTH = 4;
	localparam logic [2:0] DEPTH_RESET = 3'h0;
	// Fetch address driven onto the address bus after reset.
	localparam logic [ADDR_W-1:0] RESET_FETCH_ADDR = 21'h000000;
	localparam logic [BASE_W-1:0] BASE_RESET = 14'h0000;
endpackage : pic_pkg

/* design/pic_request_arbiter.sv */
// Prioritised interrupt controller: level arbitration, vectoring, nesting and wake-up.
`timescale 1ns/1ns
// What this block does
// - Accept 82 sources, each assigned one of four levels; sources 0 and 1 are fixed at level 3.
// - Inside a level the lowest-numbered active source wins; source 0 ranks first.
// - Normal vector address is the base register joined to the vector number.
// - Report current level code: none 00, level0 01, level1 10, level2/3 11.
// - Only a level strictly above the serviced one may preempt; others wait.
// - Level-2 request matching a fast slot is vectored to that slot's address.
// - Fast-slot selection happens here, before the core sees the request.
// - Configuration arrives as plain ports in place of the peripheral bus.
// - After reset the block drives the initial fetch address.
// - Functional mode from reset; left only during wait or stop.
// - In wait or stop, a pending request asks the clock unit to wake.
// - Only sources enabled at low-power entry can wake the device.
// - External pins become low-level sensitive during wait and stop.
// - In stop only CAN and external pins raise wake-ups.
module pic_request_arbiter (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Request lines and external pins (pins active low).
	input wire logic [pic_pkg::NUM_SRC-1:0] i_src_req,
	input wire logic i_ext_req_a_n,
	input wire logic i_ext_req_b_n,
	input wire logic i_ext_a_edge,
	input wire logic i_ext_b_edge,
	// Configuration: enables, levels, base and fast slots.
	input wire logic [pic_pkg::NUM_SRC-1:0] i_src_en,
	input wire logic [2*pic_pkg::NUM_SRC-1:0] i_level_assign_regs,
	input wire logic [pic_pkg::BASE_W-1:0] i_vector_base_reg,
	input wire logic [pic_pkg::NUM_W-1:0] i_fast_match_slot0,
	input wire logic [pic_pkg::NUM_W-1:0] i_fast_match_slot1,
	input wire logic [pic_pkg::FAST_LO_W-1:0] i_fast_handler_addr_low0,
	input wire logic [pic_pkg::FAST_HI_W-1:0] i_fast_handler_addr_high0,
	input wire logic [pic_pkg::FAST_LO_W-1:0] i_fast_handler_addr_low1,
	input wire logic [pic_pkg::FAST_HI_W-1:0] i_fast_handler_addr_high1,
	// Core handshake.
	input wire logic i_ack,
	input wire logic i_return,
	// System integration unit.
	input wire logic i_wait_mode,
	input wire logic i_stop_mode,
	// Outputs to the core and the clock unit.
	output logic o_irq_req,
	output logic [pic_pkg::NUM_W-1:0] o_vector_num,
	output logic [1:0] o_irq_level,
	output logic o_fast,
	output logic [pic_pkg::ADDR_W-1:0] o_vector_addr,
	output logic [1:0] o_current_level_code,
	output logic o_wake
);
	localparam int N = pic_pkg::NUM_SRC;

	// Index of the lowest set bit; zero when nothing is set.
	function automatic logic [pic_pkg::NUM_W-1:0] first_set(input logic [N-1:0] v);
		logic [pic_pkg::NUM_W-1:0] idx;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = pic_pkg::NUM_W'(i);
			end
		end
		return idx;
	endfunction : first_set

	// Reset release through two flip-flops.
	logic rst_meta_r;
	logic rst_sync_r;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	wire rstn = rst_sync_r;

	// Low-power state and the enable snapshot taken on entry.
	wire lp = i_wait_mode | i_stop_mode;
	logic lp_r;
	logic [N-1:0] en_snap_r;
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			lp_r <= 1'b0;
			en_snap_r <= '0;
		end else begin
			lp_r <= lp;
			if (lp && !lp_r) begin
				en_snap_r <= i_src_en;
			end
		end
	end

	// Falling-edge latches for the external pins; a new edge wins over the clearing ack.
	logic ext_a_d_r;
	logic ext_b_d_r;
	logic ext_a_pend_r;
	logic ext_b_pend_r;
	logic ack_is_a;
	logic ack_is_b;
	wire fall_a = ext_a_d_r & ~i_ext_req_a_n;
	wire fall_b = ext_b_d_r & ~i_ext_req_b_n;
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			ext_a_d_r <= 1'b1;
			ext_b_d_r <= 1'b1;
			ext_a_pend_r <= 1'b0;
			ext_b_pend_r <= 1'b0;
		end else begin
			ext_a_d_r <= i_ext_req_a_n;
			ext_b_d_r <= i_ext_req_b_n;
			ext_a_pend_r <= fall_a | (ext_a_pend_r & ~ack_is_a);
			ext_b_pend_r <= fall_b | (ext_b_pend_r & ~ack_is_b);
		end
	end

	// Edge mode needs a running clock, so low power falls back to the pin level.
	wire ext_a_act = (i_ext_a_edge && !lp) ? ext_a_pend_r : ~i_ext_req_a_n;
	wire ext_b_act = (i_ext_b_edge && !lp) ? ext_b_pend_r : ~i_ext_req_b_n;
	logic [N-1:0] act;
	always_comb begin
		act = i_src_req;
		act[pic_pkg::EXT_A_SRC] = ext_a_act;
		act[pic_pkg::EXT_B_SRC] = ext_b_act;
	end

	// Per-level request vectors; fixed sources ignore their level field.
	logic [3:0][N-1:0] lvl_vec;
	always_comb begin
		lvl_vec = '0;
		for (int i = 0; i < N; i++) begin
			if (i < pic_pkg::FIXED_SRC_CNT) begin
				lvl_vec[pic_pkg::FIXED_LEVEL][i] = act[i] & i_src_en[i];
			end else begin
				lvl_vec[i_level_assign_regs[2*i+:2]][i] = act[i] & i_src_en[i];
			end
		end
	end

	// Nesting stack of serviced levels.
	logic [1:0] stack_r [pic_pkg::STACK_DEPTH];
	logic [2:0] depth_r;
	wire [1:0] top_lvl = stack_r[depth_r[1:0] - 2'h1];
	wire busy = depth_r != pic_pkg::DEPTH_RESET;

	// Highest eligible level, then the lowest number inside it.
	logic win_ok;
	logic [1:0] win_lvl;
	always_comb begin
		win_ok = 1'b0;
		win_lvl = 2'h0;
		for (int l = 0; l < 4; l++) begin
			if (|lvl_vec[l] && (!busy || 2'(l) > top_lvl)) begin
				win_ok = 1'b1;
				win_lvl = 2'(l);
			end
		end
	end
	wire [N-1:0] win_vec = lvl_vec[win_lvl];
	wire [pic_pkg::NUM_W-1:0] win_num = first_set(win_vec);

	// Fast slots are resolved here so the core gets the final address.
	wire lvl2 = win_lvl == pic_pkg::FAST_LEVEL;
	wire hit0 = lvl2 && win_num == i_fast_match_slot0;
	wire hit1 = lvl2 && win_num == i_fast_match_slot1;
	wire [pic_pkg::ADDR_W-1:0] norm_addr = {i_vector_base_reg, win_num};
	wire [pic_pkg::ADDR_W-1:0] win_addr = hit0 ? {i_fast_handler_addr_high0,
		i_fast_handler_addr_low0} : hit1 ? {i_fast_handler_addr_high1,
		i_fast_handler_addr_low1} : norm_addr;

	assign ack_is_a = i_ack && o_vector_num == pic_pkg::EXT_A_SRC;
	assign ack_is_b = i_ack && o_vector_num == pic_pkg::EXT_B_SRC;

	// Stack push on acknowledge, pop on return; push wins if both arrive together.
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			depth_r <= pic_pkg::DEPTH_RESET;
			for (int i = 0; i < pic_pkg::STACK_DEPTH; i++) begin
				stack_r[i] <= 2'h0;
			end
		end else if (i_ack && o_irq_req && depth_r < 3'(pic_pkg::STACK_DEPTH)) begin
			stack_r[depth_r[1:0]] <= o_irq_level;
			depth_r <= depth_r + 3'h1;
		end else if (i_return && busy) begin
			depth_r <= depth_r - 3'h1;
		end
	end

	// Level code as seen after the stack update.
	logic [1:0] code_nxt;
	always_comb begin
		case (top_lvl)
			2'h0: code_nxt = pic_pkg::CODE_LVL0;
			2'h1: code_nxt = pic_pkg::CODE_LVL1;
			default: code_nxt = pic_pkg::CODE_LVL23;
		endcase
		if (!busy) begin
			code_nxt = pic_pkg::CODE_NONE;
		end
	end

	// Stop mode lets only clock-free sources wake the device.
	logic [N-1:0] stop_ok;
	always_comb begin
		stop_ok = '0;
		stop_ok[pic_pkg::CAN_WAKE_SRC] = 1'b1;
		stop_ok[pic_pkg::EXT_A_SRC] = 1'b1;
		stop_ok[pic_pkg::EXT_B_SRC] = 1'b1;
	end
	wire [N-1:0] wake_vec = act & en_snap_r & (i_stop_mode ? stop_ok : '1);
	wire wake_nxt = lp && lp_r && |wake_vec;

	// Output registers; the ack cycle drops the request so a stale vector is never retaken.
	always_ff @(posedge i_mclk or negedge rstn) begin
		if (!rstn) begin
			o_irq_req <= 1'b0;
			o_vector_num <= '0;
			o_irq_level <= 2'h0;
			o_fast <= 1'b0;
			o_vector_addr <= pic_pkg::RESET_FETCH_ADDR;
			o_current_level_code <= pic_pkg::CODE_NONE;
			o_wake <= 1'b0;
		end else begin
			o_irq_req <= win_ok && !lp && !i_ack;
			if (win_ok && !lp) begin
				o_vector_num <= win_num;
				o_irq_level <= win_lvl;
				o_fast <= hit0 | hit1;
				o_vector_addr <= win_addr;
			end
			o_current_level_code <= code_nxt;
			o_wake <= wake_nxt;
		end
	end

	// Checks.
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!rstn);

	sequence s_enter_lp;
		!lp ##1 lp;
	endsequence
	sequence s_taken;
		o_irq_req && i_ack;
	endsequence

	chk_level_code: assert property (busy && top_lvl == 2'h1 |=>
		o_current_level_code == pic_pkg::CODE_LVL1)
		else $error("level code wrong for level 1");
	chk_idle_code: assert property (!busy |=> o_current_level_code == pic_pkg::CODE_NONE)
		else $error("level code not none when idle");
	chk_normal_vector: assert property (o_irq_req && !o_fast |->
		o_vector_addr == {$past(i_vector_base_reg), o_vector_num})
		else $error("normal vector not base joined to number");
	chk_fast_select: assert property (win_ok && !lp && !i_ack && hit0 |=>
		o_fast && o_vector_addr == {$past(i_fast_handler_addr_high0),
		$past(i_fast_handler_addr_low0)})
		else $error("fast slot 0 address not selected");
	chk_fast_slot1: assert property (win_ok && !lp && !i_ack && hit1 && !hit0 |=>
		o_fast && o_vector_addr == {$past(i_fast_handler_addr_high1),
		$past(i_fast_handler_addr_low1)})
		else $error("fast slot 1 address not selected");
	chk_fast_level: assert property (o_fast |-> o_irq_level == pic_pkg::FAST_LEVEL)
		else $error("fast vector at wrong level");
	chk_nest_gate: assert property (o_irq_req && $past(busy) |->
		o_irq_level > $past(top_lvl))
		else $error("request not above serviced level");
	chk_lowest_wins: assert property (o_irq_req |->
		($past(win_vec) & ((82'h1 << o_vector_num) - 82'h1)) == '0)
		else $error("lower-numbered source skipped");
	chk_ack_drop: assert property (s_taken |=> !o_irq_req ##1 busy)
		else $error("request held after acknowledge");
	chk_lp_quiet: assert property (lp |=> !o_irq_req)
		else $error("request raised in low power");
	chk_snapshot: assert property (s_enter_lp |=> en_snap_r == $past(i_src_en))
		else $error("enables not captured on entry");
	chk_wake_cause: assert property (o_wake |-> $past(lp) && $past(|(act & en_snap_r)))
		else $error("wake without enabled pending source");
	chk_stop_filter: assert property (o_wake && $past(i_stop_mode) |->
		$past(|(act & stop_ok)))
		else $error("stop wake from clocked source");
	chk_reset_addr: assert property ($rose(rst_sync_r) |->
		o_vector_addr == pic_pkg::RESET_FETCH_ADDR)
		else $error("reset fetch address missing");
endmodule : pic_request_arbiter

/* verif/pic_core_model.sv */
// Behavioural core that takes presented interrupts and returns from handlers.
`timescale 1ns/1ns
module pic_core_model (
	// Clock.
	input wire logic i_mclk,
	// Request from the controller.
	input wire logic i_irq_req,
	input wire logic [1:0] i_irq_level,
	// Mask bits and return command.
	input wire logic [1:0] i_core_status_word,
	input wire logic i_ret_cmd,
	// Handshake back to the controller.
	output logic o_ack,
	output logic o_return
);
	// A masked level is left standing at the controller, as the real core does.
	wire allowed = i_irq_level >= i_core_status_word;
	// One ack per presented request, driven just after the clock edge.
	// Both outputs settle to zero at the first edge, while the controller is still in reset.
	always @(posedge i_mclk) begin
		o_ack <= i_irq_req & allowed & ~o_ack;
		o_return <= i_ret_cmd;
	end
endmodule : pic_core_model

/* verif/pic_request_arbiter_test.sv */
// Self-checking bench for the prioritised interrupt controller.
`timescale 1ns/1ns
module pic_request_arbiter_test;
	logic mclk, rstn, ea_n, eb_n, ea_e, eb_e, wt, st, ret_cmd, ack, ret, irq, fast, wake;
	logic [81:0] req, en;
	logic [163:0] lvl;
	logic [13:0] base;
	logic [6:0] fm0, fm1, num;
	logic [15:0] lo0, lo1;
	logic [4:0] hi0, hi1;
	logic [1:0] mask, ilv, code;
	logic [20:0] addr;
	int errors = 0;
	int num_checks = 0;
	pic_request_arbiter dut (.i_mclk(mclk), .i_rstn(rstn), .i_src_req(req),
		.i_ext_req_a_n(ea_n), .i_ext_req_b_n(eb_n), .i_ext_a_edge(ea_e), .i_ext_b_edge(eb_e),
		.i_src_en(en), .i_level_assign_regs(lvl), .i_vector_base_reg(base),
		.i_fast_match_slot0(fm0), .i_fast_match_slot1(fm1),
		.i_fast_handler_addr_low0(lo0), .i_fast_handler_addr_high0(hi0),
		.i_fast_handler_addr_low1(lo1), .i_fast_handler_addr_high1(hi1),
		.i_ack(ack), .i_return(ret), .i_wait_mode(wt), .i_stop_mode(st),
		.o_irq_req(irq), .o_vector_num(num), .o_irq_level(ilv), .o_fast(fast),
		.o_vector_addr(addr), .o_current_level_code(code), .o_wake(wake));
	pic_core_model core (.i_mclk(mclk), .i_irq_req(irq), .i_irq_level(ilv),
		.i_core_status_word(mask), .i_ret_cmd(ret_cmd), .o_ack(ack), .o_return(ret));
	// Free-running 100 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic step(input int n);
		repeat (n) @(negedge mclk);
	endtask : step
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic setl(input int s, input logic [1:0] l);
		lvl[2*s +: 2] = l;
	endtask : setl
	// Bounded wait for a request, check it, let the core take it, then check the level code.
	task automatic svc(input int s, input logic [20:0] a, input logic f, input logic [1:0] c);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 20) begin
			step(1);
			k++;
		end
		chk(irq, 1'b1);
		chk(num, s[6:0]);
		chk(addr, a);
		chk(fast, f);
		step(3);
		req[s] = 1'b0;
		chk(code, c);
	endtask : svc
	// A one-cycle return from the innermost handler.
	task automatic rtn;
		ret_cmd = 1'b1;
		step(1);
		ret_cmd = 1'b0;
		step(3);
	endtask : rtn
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	// The whole run needs under two hundred cycles, so this limit of 10000 cycles only trips on a hang.
	initial begin
		#100000;
		errors++;
		finish_test;
	end
	initial begin
		{rstn, ea_e, eb_e, wt, st, ret_cmd, req, lvl} = '0;
		{ea_n, eb_n} = 2'h3;
		en = '1;
		mask = 2'h0;
		base = 14'h1234;
		{fm0, fm1} = {7'h0C, 7'h0D};
		{lo0, hi0, lo1, hi1} = {16'hBEEF, 5'h15, 16'h1111, 5'h0A};
		step(16);
		chk(addr, 21'h0);
		chk({irq, code, wake}, 4'h0);
		rstn = 1'b1;
		step(3);
		// Two level-1 sources at once; the second must wait at equal level.
		setl(3, 2'h1);
		setl(5, 2'h1);
		req[5] = 1'b1;
		req[3] = 1'b1;
		svc(3, {base, 7'h03}, 1'b0, 2'h2);
		step(5);
		chk(irq, 1'b0);
		setl(12, 2'h2);
		req[12] = 1'b1;
		svc(12, {hi0, lo0}, 1'b1, 2'h3);
		rtn;
		chk(code, 2'h2);
		rtn;
		svc(5, {base, 7'h05}, 1'b0, 2'h2);
		rtn;
		chk(code, 2'h0);
		$display("test nesting done");
		// Slot match off level 2, a level-0 source, and a fixed source preempting it.
		setl(13, 2'h1);
		req[13] = 1'b1;
		svc(13, {base, 7'h0D}, 1'b0, 2'h2);
		rtn;
		// The same source at level 2 now takes fast slot 1.
		setl(13, 2'h2);
		req[13] = 1'b1;
		svc(13, {hi1, lo1}, 1'b1, 2'h3);
		rtn;
		req[40] = 1'b1;
		svc(40, {base, 7'h28}, 1'b0, 2'h1);
		req[0] = 1'b1;
		svc(0, {base, 7'h00}, 1'b0, 2'h3);
		rtn;
		rtn;
		// A masked level stays presented until the mask opens.
		mask = 2'h3;
		setl(20, 2'h2);
		req[20] = 1'b1;
		step(8);
		chk({irq, ilv}, 3'h6);
		mask = 2'h0;
		svc(20, {base, 7'h14}, 1'b0, 2'h3);
		rtn;
		$display("test vectoring done");
		// Wait mode: a source enabled after entry must not wake.
		en[21] = 1'b0;
		wt = 1'b1;
		step(3);
		en[21] = 1'b1;
		req[21] = 1'b1;
		step(4);
		chk({wake, irq}, 2'h0);
		req[22] = 1'b1;
		step(4);
		chk(wake, 1'b1);
		req[22:21] = 2'h0;
		wt = 1'b0;
		step(3);
		// Stop mode: clocked peripheral is silent, external pin wakes even in edge mode.
		st = 1'b1;
		step(3);
		req[30] = 1'b1;
		step(4);
		chk(wake, 1'b0);
		ea_e = 1'b1;
		ea_n = 1'b0;
		step(4);
		chk(wake, 1'b1);
		$display("test wake done");
		// Back in functional mode the edge caught in stop is served once; the held-low pin is not.
		st = 1'b0;
		req[30] = 1'b0;
		svc(9, {base, 7'h09}, 1'b0, 2'h1);
		rtn;
		chk(irq, 1'b0);
		// Pin B in level mode requests for as long as it is held low.
		eb_n = 1'b0;
		svc(10, {base, 7'h0A}, 1'b0, 2'h1);
		eb_n = 1'b1;
		rtn;
		chk({irq, code}, 3'h0);
		$display("test pins done");
		finish_test;
	end
endmodule : pic_request_arbiter_test
